//--- verilog/lfse_top.sv
// LIN frame schedule engine: schedule runner, stream output, slave
// responder and receive capture behind a classic Wishbone slave.
// Assumes a frame-level link: bit framing and checksum live outside.
//
// The Wishbone interface to the registers and the address map were decided locally.
`include "lfse_params.svh"
module lfse_top #(
  parameter int NF = 8,
  parameter int NE = 32,
  parameter int SLOT_CYC = `LFSE_SLOT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_hdr_i,
  input wire logic [5:0] rx_hdr_id_i,
  input wire logic rx_frm_i,
  input wire logic [5:0] rx_frm_id_i,
  input wire logic [3:0] rx_frm_len_i,
  input wire logic [63:0] rx_frm_dat_i,
  input wire logic collision_i,
  output logic tx_hdr_o,
  output logic [5:0] tx_hdr_id_o,
  output logic tx_rsp_o,
  output logic [3:0] tx_rsp_len_o,
  output logic [63:0] tx_rsp_dat_o,
  output logic master_o
);
  localparam int IW = $clog2(NF);
  localparam int CW = `LFSE_CW;
  localparam int US_CYC = `LFSE_US_CYC;

  // Id lookup over all enabled frame slots, first match wins
  function automatic logic [IW:0] lfse_find(input logic [5:0] id,
                                            input logic [NF*CW-1:0] cfg);
    logic [IW:0] r;
    r = '0;
    for (int k = NF - 1; k >= 0; k--) begin
      if (cfg[k*CW + `LFSE_F_EN] && cfg[k*CW +: 6] == id) begin
        r = {1'b1, IW'(k)};
      end
    end
    return r;
  endfunction : lfse_find

  // Whether an output slot answers now: cyclic if its length is nonzero, event only if also fresh
  function automatic logic lfse_rsp(input logic [CW-1:0] c, input logic p);
    return c[`LFSE_F_EN] && c[`LFSE_F_OUT] && c[`LFSE_F_LEN] != 4'h0 &&
           (!c[`LFSE_F_EVT] || p);
  endfunction : lfse_rsp

  // Bus slave
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rd_mux;
  wire acc = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr = acc && wb_we_i;
  wire [31:0] lane_m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
                        {8{wb_sel_i[0]}}};
  wire [31:0] wd = (wb_dat_i & lane_m) | (rd_mux & ~lane_m);
  wire w_ctrl = wr && wb_adr_i == `LFSE_A_CTRL;
  wire w_stat = wr && wb_adr_i == `LFSE_A_STAT;
  wire w_sreq = wr && wb_adr_i == `LFSE_A_SREQ;
  wire w_sadr = wr && wb_adr_i == `LFSE_A_SADR;
  wire w_sdat = wr && wb_adr_i == `LFSE_A_SDAT;
  wire w_fsel = wr && wb_adr_i == `LFSE_A_FSEL;
  wire w_fcfg = wr && wb_adr_i == `LFSE_A_FCFG;
  wire w_fd0 = wr && wb_adr_i == `LFSE_A_FD0;
  wire w_fd1 = wr && wb_adr_i == `LFSE_A_FD1;
  wire w_sid = wr && wb_adr_i == `LFSE_A_STRID;
  wire w_sd0 = wr && wb_adr_i == `LFSE_A_STRD0;
  wire w_sd1 = wr && wb_adr_i == `LFSE_A_STRD1;
  wire w_sts = wr && wb_adr_i == `LFSE_A_STRTS;
  wire r_fd1 = acc && !wb_we_i && wb_adr_i == `LFSE_A_FD1;
  wire r_rxd1 = acc && !wb_we_i && wb_adr_i == `LFSE_A_RXD1;

  // Software-visible state
  logic [1:0] ctrl_q;
  logic master_q;
  logic err_q;
  logic [4:0] sadr_q;
  logic [`LFSE_EW-1:0] sched_q [NE];
  logic [IW-1:0] fsel_q;
  logic [31:0] fd0_q;
  logic [15:0] sid_q;
  logic [31:0] sd0_q;
  logic [31:0] sd1_q;
  logic [31:0] sts_q;
  logic str_pend_q;
  logic [15:0] rxid_q;
  logic [63:0] rxd_q;
  logic [31:0] time_q;
  logic [7:0] us_q;

  // Scheduler state
  logic cont_act_q;
  logic once_act_q;
  logic crs_act_q;
  logic [4:0] cont_start_q;
  logic [4:0] cont_ptr_q;
  logic [4:0] once_ptr_q;
  logic [4:0] crs_ptr_q;
  logic [4:0] crs_lat_q;
  logic slot_et_q;
  logic [31:0] slot_q;

  // Frame store
  logic [NF*CW-1:0] cfg_all;
  logic [NF-1:0] pend_all;
  logic [NF-1:0] new_all;
  logic [63:0] sel_dat;
  logic [63:0] tx_dat;
  logic [IW-1:0] tx_idx;
  logic tx_clr;
  wire [CW-1:0] scfg = cfg_all[fsel_q*CW +: CW];
  // Slave has no schedule to resample against
  wire wave_refused = w_fd1 && scfg[`LFSE_F_WAVE] && !master_q;
  wire str_refused = w_sd1 && !master_q;
  wire pay_we = w_fd1 && !wave_refused;
  wire [IW:0] r_fnd = lfse_find(rx_frm_id_i, cfg_all);
  wire [CW-1:0] rcfg = cfg_all[r_fnd[IW-1:0]*CW +: CW];
  wire rx_we = rx_frm_i && r_fnd[IW] && !rcfg[`LFSE_F_OUT];

  lfse_frame_store #(.NF(NF), .IW(IW)) u_store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(fsel_q),
    .cfg_we_i(w_fcfg),
    .cfg_i(wd[CW-1:0]),
    .pay_we_i(pay_we),
    .pay_i({wd, fd0_q}),
    .rd_clr_i(r_fd1),
    .tx_clr_i(tx_clr),
    .tx_idx_i(tx_idx),
    .rx_we_i(rx_we),
    .rx_idx_i(r_fnd[IW-1:0]),
    .rx_len_i(rx_frm_len_i),
    .rx_dat_i(rx_frm_dat_i),
    .cfg_o(cfg_all),
    .pend_o(pend_all),
    .new_o(new_all),
    .sel_dat_o(sel_dat),
    .tx_dat_o(tx_dat)
  );

  assign rd_mux =
    (wb_adr_i == `LFSE_A_CTRL) ? {30'h0, ctrl_q} :
    (wb_adr_i == `LFSE_A_STAT) ? {28'h0, err_q, str_pend_q, once_act_q | crs_act_q,
                                  master_q} :
    (wb_adr_i == `LFSE_A_SADR) ? {27'h0, sadr_q} :
    (wb_adr_i == `LFSE_A_SDAT) ? {10'h0, sched_q[sadr_q]} :
    (wb_adr_i == `LFSE_A_FSEL) ? 32'(fsel_q) :
    (wb_adr_i == `LFSE_A_FCFG) ? 32'(scfg) :
    (wb_adr_i == `LFSE_A_FD0) ? sel_dat[31:0] :
    (wb_adr_i == `LFSE_A_FD1) ? sel_dat[63:32] :
    (wb_adr_i == `LFSE_A_FSTAT) ? {30'h0, new_all[fsel_q], pend_all[fsel_q]} :
    (wb_adr_i == `LFSE_A_STRID) ? {16'h0, sid_q} :
    (wb_adr_i == `LFSE_A_STRD0) ? sd0_q :
    (wb_adr_i == `LFSE_A_STRD1) ? sd1_q :
    (wb_adr_i == `LFSE_A_STRTS) ? sts_q :
    (wb_adr_i == `LFSE_A_RXID) ? {16'h0, rxid_q} :
    (wb_adr_i == `LFSE_A_RXD0) ? rxd_q[31:0] :
    (wb_adr_i == `LFSE_A_RXD1) ? rxd_q[63:32] :
    (wb_adr_i == `LFSE_A_TIME) ? time_q : 32'h0000_0000;

  wire run = master_q && ctrl_q[0];
  wire bnd = run && slot_q == 32'h0;
  wire replay = ctrl_q[1];
  wire str_ready = str_pend_q && (!replay || time_q >= sts_q);
  // Stream waits behind run-once, steps in front of continuous
  wire src_crs = crs_act_q;
  wire src_once = once_act_q && !crs_act_q;
  wire src_str = str_ready && !crs_act_q && !once_act_q;
  wire src_cont = cont_act_q && !crs_act_q && !once_act_q && !str_ready;
  lfse_pkg::lfse_src_t src;
  assign src = src_crs ? lfse_pkg::LFSE_SRC_CRS :
               src_once ? lfse_pkg::LFSE_SRC_ONCE :
               src_str ? lfse_pkg::LFSE_SRC_STR :
               src_cont ? lfse_pkg::LFSE_SRC_CONT : lfse_pkg::LFSE_SRC_NONE;
  wire go = bnd && src != lfse_pkg::LFSE_SRC_NONE;
  wire [4:0] ptr = src_crs ? crs_ptr_q : src_once ? once_ptr_q : cont_ptr_q;
  wire [`LFSE_EW-1:0] ent = sched_q[ptr];
  wire ent_last = ent[`LFSE_E_LAST];
  lfse_pkg::lfse_kind_t kind;
  assign kind = lfse_pkg::lfse_kind_t'(ent[`LFSE_E_KIND]);

  // Sporadic pick: first pending frame in list order
  logic sp_hit;
  logic [IW-1:0] sp_idx;
  always_comb begin
    sp_hit = 1'b0;
    sp_idx = '0;
    for (int j = 3; j >= 0; j--) begin
      if (j <= int'(ent[`LFSE_E_CNT]) && pend_all[IW'(ent[`LFSE_E_F0 + 3*j +: 3])]) begin
        sp_hit = 1'b1;
        sp_idx = IW'(ent[`LFSE_E_F0 + 3*j +: 3]);
      end
    end
  end

  wire [IW-1:0] m_idx = (kind == lfse_pkg::LFSE_ENT_SPOR) ? sp_idx :
                        IW'(ent[`LFSE_E_F0 +: 3]);
  wire [CW-1:0] mcfg = cfg_all[m_idx*CW +: CW];
  wire ent_ok = mcfg[`LFSE_F_EN] && (kind != lfse_pkg::LFSE_ENT_SPOR || sp_hit);
  wire m_sched = go && !src_str;
  // Header opens an entry only if its frame is enabled and, for sporadic, one is pending; response only from the owner
  wire m_hdr = (m_sched && ent_ok) || (go && src_str);
  wire m_rsp_s = m_sched && ent_ok && lfse_rsp(mcfg, pend_all[m_idx]);
  wire [3:0] str_len = sid_q[`LFSE_S_LEN];
  wire m_rsp_t = go && src_str && str_len != 4'h0;
  wire [5:0] str_hid = (replay && sid_q[`LFSE_S_ET]) ? sd0_q[5:0] :
                       sid_q[`LFSE_S_ID];

  // Slave answers only a header naming its frame
  wire [IW:0] s_fnd = lfse_find(rx_hdr_id_i, cfg_all);
  wire [CW-1:0] s_cfg = cfg_all[s_fnd[IW-1:0]*CW +: CW];
  wire s_rsp = !master_q && rx_hdr_i && s_fnd[IW] &&
               lfse_rsp(s_cfg, pend_all[s_fnd[IW-1:0]]);
  assign tx_idx = master_q ? m_idx : s_fnd[IW-1:0];
  wire [CW-1:0] tcfg = cfg_all[tx_idx*CW +: CW];
  assign tx_clr = m_rsp_s || s_rsp;
  wire et_slot = (m_sched && kind == lfse_pkg::LFSE_ENT_EVTRIG) ||
                 (go && src_str && !replay && sid_q[`LFSE_S_ET]);
  wire [4:0] crs_start = src_str ? sid_q[`LFSE_S_CRS] : ent[`LFSE_E_CRS];
  wire collided = run && slot_et_q && collision_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      rdat_q <= acc ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= 2'h0;
      sadr_q <= 5'h00;
      fsel_q <= '0;
      fd0_q <= 32'h0000_0000;
      sid_q <= 16'h0000;
      sd0_q <= 32'h0000_0000;
      sd1_q <= 32'h0000_0000;
      sts_q <= 32'h0000_0000;
    end else begin
      if (w_ctrl) ctrl_q <= wd[1:0];
      if (w_sadr) sadr_q <= wd[4:0];
      if (w_fsel) fsel_q <= wd[IW-1:0];
      if (w_fd0) fd0_q <= wd;
      if (w_sid && !str_pend_q) sid_q <= wd[15:0];
      if (w_sd0 && !str_pend_q) sd0_q <= wd;
      if (w_sd1 && master_q && !str_pend_q) sd1_q <= wd;
      if (w_sts && !str_pend_q) sts_q <= wd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (w_sdat) sched_q[sadr_q] <= wd[`LFSE_EW-1:0];
  end

  // Error, stream pending, receive capture, time base
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
      str_pend_q <= 1'b0;
      rxid_q <= 16'h0000;
      rxd_q <= 64'h0;
      us_q <= 8'h00;
      time_q <= 32'h0000_0000;
    end else begin
      if (wave_refused || str_refused) err_q <= 1'b1;
      else if (w_stat && wd[3]) err_q <= 1'b0;
      // One shot per write, never cyclic
      if (w_sd1 && master_q && !str_pend_q) str_pend_q <= 1'b1;
      else if (go && src_str) str_pend_q <= 1'b0;
      if (rx_frm_i) begin
        rxid_q <= {5'h00, 1'b1, rx_frm_len_i, rx_frm_id_i};
        rxd_q <= rx_frm_dat_i;
      end else if (r_rxd1) begin
        rxid_q[10] <= 1'b0;
      end
      us_q <= (us_q == 8'(US_CYC - 1)) ? 8'h00 : us_q + 8'h01;
      if (us_q == 8'(US_CYC - 1)) time_q <= time_q + 32'h1;
    end
  end

  // Schedule runner; every entry holds one slot time, so a single-entry
  // frame recurs once per pass over the table
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_q <= 1'b0;
      cont_act_q <= 1'b0;
      once_act_q <= 1'b0;
      crs_act_q <= 1'b0;
      cont_start_q <= 5'h00;
      cont_ptr_q <= 5'h00;
      once_ptr_q <= 5'h00;
      crs_ptr_q <= 5'h00;
      crs_lat_q <= 5'h00;
      slot_et_q <= 1'b0;
      slot_q <= 32'h0000_0000;
    end else begin
      if (go) slot_q <= 32'(SLOT_CYC - 1);
      else if (slot_q != 32'h0) slot_q <= slot_q - 32'h1;
      if (go) begin
        slot_et_q <= et_slot;
        crs_lat_q <= crs_start;
      end else if (collided) begin
        slot_et_q <= 1'b0;
      end
      if (go && src_crs) begin
        if (ent_last) crs_act_q <= 1'b0;
        crs_ptr_q <= ptr + 5'h01;
      end else if (collided) begin
        crs_act_q <= 1'b1;
        crs_ptr_q <= crs_lat_q;
      end
      if (go && src_once) begin
        if (ent_last) once_act_q <= 1'b0;
        once_ptr_q <= ptr + 5'h01;
      end
      if (go && src_cont) cont_ptr_q <= ent_last ? cont_start_q : ptr + 5'h01;
      // Host request turns the interface into master
      if (w_sreq) begin
        master_q <= 1'b1;
        if (wd[5]) begin
          once_act_q <= 1'b1;
          once_ptr_q <= wd[4:0];
        end else begin
          cont_act_q <= 1'b1;
          cont_start_q <= wd[4:0];
          cont_ptr_q <= wd[4:0];
        end
      end
    end
  end

  // Link outputs; at most one header per entry execution
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_hdr_o <= 1'b0;
      tx_hdr_id_o <= 6'h00;
      tx_rsp_o <= 1'b0;
      tx_rsp_len_o <= 4'h0;
      tx_rsp_dat_o <= 64'h0;
      master_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
    end else begin
      tx_hdr_o <= m_hdr;
      if (m_hdr) tx_hdr_id_o <= src_str ? str_hid : mcfg[`LFSE_F_ID];
      tx_rsp_o <= m_rsp_s || m_rsp_t || s_rsp;
      if (m_rsp_t) begin
        tx_rsp_len_o <= str_len;
        tx_rsp_dat_o <= {sd1_q, sd0_q};
      end else if (m_rsp_s || s_rsp) begin
        tx_rsp_len_o <= tcfg[`LFSE_F_LEN];
        tx_rsp_dat_o <= tx_dat;
      end
      master_o <= master_q;
      wb_dat_o <= acc ? rd_mux : rdat_q;
      wb_ack_o <= acc;
    end
  end
endmodule : lfse_top

//--- verilog/lfse_params.svh
// Constants of the LIN frame schedule engine: offsets, fields, timing.
// Assumes inclusion by the top and frame store design files.
`ifndef LFSE_PARAMS_SVH
`define LFSE_PARAMS_SVH
`define LFSE_A_CTRL 8'h00
`define LFSE_A_STAT 8'h04
`define LFSE_A_SREQ 8'h08
`define LFSE_A_SADR 8'h0C
`define LFSE_A_SDAT 8'h10
`define LFSE_A_FSEL 8'h14
`define LFSE_A_FCFG 8'h18
`define LFSE_A_FD0 8'h1C
`define LFSE_A_FD1 8'h20
`define LFSE_A_FSTAT 8'h24
`define LFSE_A_STRID 8'h28
`define LFSE_A_STRD0 8'h2C
`define LFSE_A_STRD1 8'h30
`define LFSE_A_STRTS 8'h34
`define LFSE_A_RXID 8'h38
`define LFSE_A_RXD0 8'h3C
`define LFSE_A_RXD1 8'h40
`define LFSE_A_TIME 8'h44
`define LFSE_CW 14
`define LFSE_F_ID 5:0
`define LFSE_F_OUT 6
`define LFSE_F_EVT 7
`define LFSE_F_WAVE 8
`define LFSE_F_LEN 12:9
`define LFSE_F_EN 13
`define LFSE_EW 22
`define LFSE_E_KIND 1:0
`define LFSE_E_CNT 3:2
`define LFSE_E_F0 4
`define LFSE_E_CRS 20:16
`define LFSE_E_LAST 21
`define LFSE_S_ID 5:0
`define LFSE_S_ET 6
`define LFSE_S_LEN 10:7
`define LFSE_S_CRS 15:11
`define LFSE_TICK_NS 1000
`define LFSE_CLK_NS 10
`define LFSE_US_CYC (`LFSE_TICK_NS / `LFSE_CLK_NS)
`define LFSE_SLOT_US 5000
`define LFSE_SLOT_CYC (`LFSE_SLOT_US * `LFSE_US_CYC)
`endif

//--- verilog/lfse_pkg.sv
// Types of the LIN frame schedule engine.
// Assumes nothing beyond the constants header.
package lfse_pkg;
  typedef enum logic [1:0] {
    LFSE_ENT_UNCOND = 2'b00,
    LFSE_ENT_SPOR = 2'b01,
    LFSE_ENT_EVTRIG = 2'b10
  } lfse_kind_t;
  typedef enum logic [2:0] {
    LFSE_SRC_NONE = 3'b000,
    LFSE_SRC_CRS = 3'b001,
    LFSE_SRC_ONCE = 3'b010,
    LFSE_SRC_STR = 3'b011,
    LFSE_SRC_CONT = 3'b100
  } lfse_src_t;
endpackage : lfse_pkg

//--- verilog/lfse_frame_store.sv
// Per-frame configuration, payload, pending and new-data flags.
// Assumes one write per slot per cycle from the top; reads are combinational.
`include "lfse_params.svh"
module lfse_frame_store #(
  parameter int NF = 8,
  parameter int IW = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [IW-1:0] sel_i,
  input wire logic cfg_we_i,
  input wire logic [`LFSE_CW-1:0] cfg_i,
  input wire logic pay_we_i,
  input wire logic [63:0] pay_i,
  input wire logic rd_clr_i,
  input wire logic tx_clr_i,
  input wire logic [IW-1:0] tx_idx_i,
  input wire logic rx_we_i,
  input wire logic [IW-1:0] rx_idx_i,
  input wire logic [3:0] rx_len_i,
  input wire logic [63:0] rx_dat_i,
  output logic [NF*`LFSE_CW-1:0] cfg_o,
  output logic [NF-1:0] pend_o,
  output logic [NF-1:0] new_o,
  output logic [63:0] sel_dat_o,
  output logic [63:0] tx_dat_o
);
  logic [NF*64-1:0] dat_all;

  for (genvar k = 0; k < NF; k++) begin : g_slot
    logic [`LFSE_CW-1:0] cfg_q;
    logic [63:0] dat_q;
    logic pend_q;
    logic new_q;
    wire sel_hit = sel_i == IW'(k);
    wire rx_hit = rx_we_i && rx_idx_i == IW'(k);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cfg_q <= '0;
        dat_q <= '0;
        pend_q <= 1'b0;
        new_q <= 1'b0;
      end else begin
        if (cfg_we_i && sel_hit) begin
          cfg_q <= cfg_i;
        end else if (rx_hit) begin
          cfg_q[`LFSE_F_LEN] <= rx_len_i;
        end
        // Payload is replaced only by a new write or a received frame, so a resend repeats it
        if (pay_we_i && sel_hit) begin
          dat_q <= pay_i;
        end else if (rx_hit) begin
          dat_q <= rx_dat_i;
        end
        // Fresh write beats a same-cycle consume
        if (pay_we_i && sel_hit) begin
          pend_q <= 1'b1;
        end else if (tx_clr_i && tx_idx_i == IW'(k)) begin
          pend_q <= 1'b0;
        end
        if (rx_hit) begin
          new_q <= 1'b1;
        end else if (rd_clr_i && sel_hit) begin
          new_q <= 1'b0;
        end
      end
    end
    assign cfg_o[k*`LFSE_CW +: `LFSE_CW] = cfg_q;
    assign dat_all[k*64 +: 64] = dat_q;
    assign pend_o[k] = pend_q;
    assign new_o[k] = new_q;
  end

  assign sel_dat_o = dat_all[sel_i*64 +: 64];
  assign tx_dat_o = dat_all[tx_idx_i*64 +: 64];
endmodule : lfse_frame_store

//--- tb/lfse_sva.sv
// Checker for the frame schedule engine: bus handshake and link pulses.
// Assumes a bind to lfse_top, one clock and a synchronous reset.
module lfse_sva #(
  parameter int SLOT_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic rx_hdr_i,
  input wire logic tx_hdr_o,
  input wire logic tx_rsp_o,
  input wire logic [3:0] tx_rsp_len_o,
  input wire logic master_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap_q;
  logic seen_q;
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Cycles since the last header; reset forgets the history
  always_ff @(posedge clk_i) begin
    gap_q <= (rst_i || tx_hdr_o) ? 0 : gap_q + 1;
    seen_q <= rst_i ? 1'b0 : (seen_q | tx_hdr_o);
  end
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_reset_quiet: assert property ($fell(rst_i) |-> !master_o && !tx_hdr_o && !tx_rsp_o)
    else $error("not idle slave after reset");
  a_master_sticky: assert property (master_o |=> master_o)
    else $error("master role lost");
  a_slave_no_hdr: assert property (!master_o |-> !tx_hdr_o)
    else $error("header sent as slave");
  a_hdr_with_rsp: assert property (master_o && tx_rsp_o |-> tx_hdr_o)
    else $error("master response without header");
  a_slave_rsp_cause: assert property (!master_o && tx_rsp_o |-> $past(rx_hdr_i))
    else $error("slave response without header");
  a_slot_spacing: assert property (tx_hdr_o && seen_q |-> gap_q >= SLOT_CYC - 1)
    else $error("headers closer than one slot");
  a_rsp_has_bytes: assert property (tx_rsp_o |-> tx_rsp_len_o != 4'h0)
    else $error("empty response");
  c_hdr_only: cover property (tx_hdr_o && !tx_rsp_o);
  c_full_frame: cover property (tx_hdr_o && tx_rsp_o);
  c_slave_answer: cover property (!master_o && tx_rsp_o);
endmodule : lfse_sva

//--- tb/lfse_remote_ecu.sv
// Remote LIN ECU model: puts headers and frames on the engine's link side.
// Assumes its tasks are called right after a rising clock edge.
module lfse_remote_ecu (
  input wire logic clk_i,
  output logic hdr_o,
  output logic [5:0] hdr_id_o,
  output logic frm_o,
  output logic [5:0] frm_id_o,
  output logic [3:0] frm_len_o,
  output logic [63:0] frm_dat_o,
  output logic coll_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {hdr_o, frm_o, coll_o} = 3'h0;
    {hdr_id_o, frm_id_o, frm_len_o, frm_dat_o} = '1;
  end
  // Acts as master while the engine is still a slave
  task automatic header(input logic [5:0] id);
    hdr_o <= 1'b1;
    hdr_id_o <= id;
    @(posedge clk_i);
    hdr_o <= 1'b0;
    // Released lines show a wrong value, never the last one
    hdr_id_o <= ~id;
    @(posedge clk_i);
  endtask : header
  task automatic frame(input logic [5:0] id, input logic [3:0] n, input logic [63:0] d);
    frm_o <= 1'b1;
    {frm_id_o, frm_len_o, frm_dat_o} <= {id, n, d};
    @(posedge clk_i);
    frm_o <= 1'b0;
    {frm_id_o, frm_len_o, frm_dat_o} <= ~{id, n, d};
    @(posedge clk_i);
  endtask : frame
  // Another responder talks over an event-triggered slot
  task automatic collide();
    coll_o <= 1'b1;
    @(posedge clk_i);
    coll_o <= 1'b0;
    @(posedge clk_i);
  endtask : collide
endmodule : lfse_remote_ecu

//--- tb/testbench.sv
// Self-checking bench of the frame schedule engine: slave reply, schedules,
// stream output and receive capture. Assumes the remote ECU model beside it.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOT = 20;
  typedef struct packed {logic h; logic [5:0] id; logic r; logic [3:0] n; logic [63:0] d;} lfse_exp_t;
  logic clk_i;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rx_hdr_i, rx_frm_i, collision_i, tx_hdr_o, tx_rsp_o, master_o;
  logic [5:0] rx_hdr_id_i, rx_frm_id_i, tx_hdr_id_o;
  logic [3:0] rx_frm_len_i, tx_rsp_len_o;
  logic [63:0] rx_frm_dat_i, tx_rsp_dat_o, p0, p1;
  logic [31:0] seed_q = 32'hE3B5F7A8;
  lfse_exp_t lq[$];
  lfse_exp_t got;
  logic [31:0] rq[$];
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc_n = 0;
  int last_n = 0;
  lfse_top #(.SLOT_CYC(SLOT)) u_lfse_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_hdr_i(rx_hdr_i), .rx_hdr_id_i(rx_hdr_id_i),
    .rx_frm_i(rx_frm_i), .rx_frm_id_i(rx_frm_id_i), .rx_frm_len_i(rx_frm_len_i),
    .rx_frm_dat_i(rx_frm_dat_i), .collision_i(collision_i), .tx_hdr_o(tx_hdr_o),
    .tx_hdr_id_o(tx_hdr_id_o), .tx_rsp_o(tx_rsp_o), .tx_rsp_len_o(tx_rsp_len_o),
    .tx_rsp_dat_o(tx_rsp_dat_o), .master_o(master_o)
  );
  lfse_remote_ecu u_lfse_remote_ecu (
    .clk_i(clk_i), .hdr_o(rx_hdr_i), .hdr_id_o(rx_hdr_id_i), .frm_o(rx_frm_i),
    .frm_id_o(rx_frm_id_i), .frm_len_o(rx_frm_len_i), .frm_dat_o(rx_frm_dat_i),
    .coll_o(collision_i)
  );
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] rnd();
    seed_q ^= seed_q << 13;
    seed_q ^= seed_q >> 17;
    seed_q ^= seed_q << 5;
    return seed_q;
  endfunction : rnd
  task automatic chk(input logic [75:0] g, input logic [75:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, we, 4'hF};
    {wb_adr_i, wb_dat_i} <= {a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) n_mismatch++;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic pay(input logic [31:0] s, input logic [31:0] cfg, input logic [63:0] d);
    wr(8'h14, s);
    wr(8'h18, cfg);
    wr(8'h1C, d[31:0]);
    wr(8'h20, d[63:32]);
  endtask : pay
  task automatic wait_q();
    int n;
    n = 0;
    while (lq.size() != 0 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    chk(76'(lq.size()), 76'h0);
  endtask : wait_q
  task automatic strm(input logic [31:0] idw, input logic [63:0] d, input logic [31:0] ts,
                      input lfse_exp_t e);
    wr(8'h28, idw);
    wr(8'h2C, d[31:0]);
    wr(8'h34, ts);
    lq.push_back(e);
    wr(8'h30, d[63:32]);
    // A future timestamp keeps the frame pending
    if (ts != 32'h0) rd(8'h04, 32'h5);
    wait_q();
  endtask : strm
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // Results are matched against the oldest note as they appear
  always @(posedge clk_i) begin
    cyc_n++;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk(76'(wb_dat_o), 76'(rq.pop_front()));
    if (tx_hdr_o === 1'b1 || tx_rsp_o === 1'b1) begin
      got = '{tx_hdr_o, tx_hdr_o ? tx_hdr_id_o : 6'h0, tx_rsp_o,
             tx_rsp_o ? tx_rsp_len_o : 4'h0, tx_rsp_o ? tx_rsp_dat_o : 64'h0};
      chk(got, lq.size() != 0 ? lq.pop_front() : lfse_exp_t'(0));
      if (tx_hdr_o === 1'b1 && tx_hdr_id_o === 6'h11) begin
        if (last_n != 0) chk(76'(cyc_n - last_n), 76'(2 * SLOT));
        last_n = cyc_n;
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    do_reset();
    rd(8'h04, 32'h0);
    rd(8'h4C, 32'h0);
    p0 = {rnd(), rnd()};
    p1 = {rnd(), rnd()};
    pay(32'h0, 32'h3051, p0);
    wr(8'h14, 32'h1);
    wr(8'h18, 32'h28D2);
    u_lfse_remote_ecu.header(6'h12);
    lq.push_back('{1'b0, 6'h0, 1'b1, 4'h8, p0});
    u_lfse_remote_ecu.header(6'h11);
    wait_q();
    wr(8'h30, rnd());
    rd(8'h04, 32'h8);
    wr(8'h04, 32'h8);
    // Waveform slot written as slave is refused
    wr(8'h14, 32'h2);
    wr(8'h18, 32'h3153);
    wr(8'h20, rnd());
    rd(8'h04, 32'h8);
    rd(8'h24, 32'h0);
    wr(8'h04, 32'h8);
    pay(32'h1, 32'h28D2, p1);
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h0C, 32'h1);
    wr(8'h10, 32'h200010);
    wr(8'h08, 32'h0);
    rd(8'h04, 32'h1);
    lq.push_back('{1'b1, 6'h11, 1'b1, 4'h8, p0});
    lq.push_back('{1'b1, 6'h12, 1'b1, 4'h4, p1});
    lq.push_back('{1'b1, 6'h11, 1'b1, 4'h8, p0});
    lq.push_back('{1'b1, 6'h12, 1'b0, 4'h0, 64'h0});
    lq.push_back('{1'b1, 6'h11, 1'b1, 4'h8, p0});
    wr(8'h00, 32'h1);
    wait_q();
    wr(8'h00, 32'h0);
    do_reset();
    // Later slot written first so list order, not write order, decides
    pay(32'h1, 32'h30E2, p1);
    pay(32'h0, 32'h24E1, p0);
    wr(8'h0C, 32'h2);
    wr(8'h10, 32'h200085);
    wr(8'h08, 32'h2);
    lq.push_back('{1'b1, 6'h21, 1'b1, 4'h2, p0});
    lq.push_back('{1'b1, 6'h22, 1'b1, 4'h8, p1});
    wr(8'h00, 32'h1);
    wait_q();
    strm(32'h15, 64'h0, 32'h0, '{1'b1, 6'h15, 1'b0, 4'h0, 64'h0});
    p1 = {rnd(), rnd()};
    strm(32'h416, p1, 32'h0, '{1'b1, 6'h16, 1'b1, 4'h8, p1});
    // Entry 3 event-triggered on slot 0, resolved by entry 4
    wr(8'h0C, 32'h4);
    wr(8'h10, 32'h200000);
    wr(8'h0C, 32'h3);
    wr(8'h10, 32'h240002);
    strm(32'h2055, 64'h0, 32'h0, '{1'b1, 6'h15, 1'b0, 4'h0, 64'h0});
    lq.push_back('{1'b1, 6'h21, 1'b0, 4'h0, 64'h0});
    u_lfse_remote_ecu.collide();
    wait_q();
    lq.push_back('{1'b1, 6'h21, 1'b0, 4'h0, 64'h0});
    wr(8'h08, 32'h23);
    wait_q();
    lq.push_back('{1'b1, 6'h21, 1'b0, 4'h0, 64'h0});
    u_lfse_remote_ecu.collide();
    wait_q();
    wr(8'h00, 32'h3);
    p0[7:0] = 8'h21;
    strm(32'h456, p0, 32'h10, '{1'b1, 6'h21, 1'b1, 4'h8, p0});
    repeat (4 * SLOT) @(posedge clk_i); // Quiet slots, nothing resent
    rd(8'h04, 32'h1);
    p0 = {rnd(), rnd()};
    u_lfse_remote_ecu.frame(6'h30, 4'h8, p0);
    rd(8'h38, 32'h630);
    rd(8'h3C, p0[31:0]);
    rd(8'h40, p0[63:32]);
    rd(8'h38, 32'h230);
    report_and_stop();
  end
endmodule : testbench
bind lfse_top lfse_sva #(.SLOT_CYC(SLOT_CYC)) u_lfse_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .rx_hdr_i(rx_hdr_i), .tx_hdr_o(tx_hdr_o),
  .tx_rsp_o(tx_rsp_o), .tx_rsp_len_o(tx_rsp_len_o), .master_o(master_o)
);
